// ==== hdl/ipfs_top.sv ====
// Input port pin function select: mode register, pin routing, edge sensing
//
// Behaviour
// - Select bit 0: pin 3 digital or analog 3
// - Select bit 1: pin 3 interrupt or timer
// - Shared pin edge: rising or falling selectable
// - Pin 3 decode: 0111 analog, 111 timer
// - Pins 7,6 analog at 1011,1010
// - Pins 5,4 analog at 1001,1000
// - Pins 2,1,0 analog at 0110,0101,0100
// - Data read gives pins; analog pins read 0
// - Mode register resets F7, reserved read one
`timescale 1ns/1ps
module ipfs_top (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // Mode register write/read
  input wire logic MODE_WR,
  input wire logic [7:0] MODE_WDATA,
  output logic [7:0] MODE_RDATA,
  // Configuration from converter, timer and interrupt logic
  input wire ipfs_pkg::ipfs_cfg_s CFG,
  // External pins
  input wire logic [7:0] PIN_IN,
  // Port data read value
  output logic [7:0] DATA_RDATA,
  // Consumers
  output logic [7:0] ANALOG_EN,
  output logic [7:0] ANALOG_PIN,
  output logic INTR_EN,
  output logic INTR_LEVEL,
  output logic INTR_EDGE,
  output logic TIMER_EN,
  output logic TIMER_LEVEL,
  output logic TIMER_EDGE
);
  import ipfs_pkg::*;

  // Registered state and its next value
  ipfs_state_s st_reg;
  ipfs_state_s st_next;
  // Function enables handed to the consumers
  ipfs_sel_s sel;
  // Pins claimed by a function other than digital or analog
  logic [7:0] taken;
  // Raw per-pin decode from the selector instances
  logic [7:0] an_en;
  logic [7:0] dg_en;
  // Function that currently owns the shared pin
  ipfs_fn_e pin3_fn;

  // Only the shared pin can be claimed by interrupt or timer;
  // the other pins are never claimed, so their selectors see zero.
  // A claimed pin is neither digital nor analog in its selector.
  always_comb begin
    taken = 8'h00;
    taken[IPFS_SHARED_PIN] = st_reg.int_pin_sel;
  end

  // One selector per pin keeps the decode uniform. Each instance
  // compares the channel field with its own code, so a code that
  // matches no pin, such as the low four, leaves every unclaimed pin digital.
  // Codes are fixed per pin rather than indexed, which keeps the
  // mapping readable at the cost of a longer listing.
  // At most one pin matches, so the converter never sees two pins.

  // Pin 0: analog channel 0
  ipfs_pin_sel #(
    .CODE(IPFS_CH0)
  ) ipfs_pin_sel_0_i (
    .channel(CFG.channel),
    .taken(taken[0]),
    .analog_en(an_en[0]),
    .digital_en(dg_en[0])
  );

  // Pin 1: analog channel 1
  ipfs_pin_sel #(
    .CODE(IPFS_CH1)
  ) ipfs_pin_sel_1_i (
    .channel(CFG.channel),
    .taken(taken[1]),
    .analog_en(an_en[1]),
    .digital_en(dg_en[1])
  );

  // Pin 2: analog channel 2
  ipfs_pin_sel #(
    .CODE(IPFS_CH2)
  ) ipfs_pin_sel_2_i (
    .channel(CFG.channel),
    .taken(taken[2]),
    .analog_en(an_en[2]),
    .digital_en(dg_en[2])
  );

  // Pin 3: analog channel 3 only while not claimed
  ipfs_pin_sel #(
    .CODE(IPFS_CH3)
  ) ipfs_pin_sel_3_i (
    .channel(CFG.channel),
    .taken(taken[3]),
    .analog_en(an_en[3]),
    .digital_en(dg_en[3])
  );

  // Pin 4: analog channel 4
  ipfs_pin_sel #(
    .CODE(IPFS_CH4)
  ) ipfs_pin_sel_4_i (
    .channel(CFG.channel),
    .taken(taken[4]),
    .analog_en(an_en[4]),
    .digital_en(dg_en[4])
  );

  // Pin 5: analog channel 5
  ipfs_pin_sel #(
    .CODE(IPFS_CH5)
  ) ipfs_pin_sel_5_i (
    .channel(CFG.channel),
    .taken(taken[5]),
    .analog_en(an_en[5]),
    .digital_en(dg_en[5])
  );

  // Pin 6: analog channel 6
  ipfs_pin_sel #(
    .CODE(IPFS_CH6)
  ) ipfs_pin_sel_6_i (
    .channel(CFG.channel),
    .taken(taken[6]),
    .analog_en(an_en[6]),
    .digital_en(dg_en[6])
  );

  // Pin 7: analog channel 7
  ipfs_pin_sel #(
    .CODE(IPFS_CH7)
  ) ipfs_pin_sel_7_i (
    .channel(CFG.channel),
    .taken(taken[7]),
    .analog_en(an_en[7]),
    .digital_en(dg_en[7])
  );

  // Shared pin function: the select bit picks the digital/analog pair
  // or the interrupt/timer pair; the field of the chosen consumer then
  // picks one of the two. The field of the other pair is ignored, so
  // a stale timer code cannot steal the pin from the converter.
  // Unused combinations fall back to digital input.
  always_comb begin
    case ({st_reg.int_pin_sel, CFG.timer_clk == IPFS_TMR_EXT, CFG.channel == IPFS_CH3})
      3'b000, 3'b010: pin3_fn = IPFS_FN_DIGITAL;
      3'b001, 3'b011: pin3_fn = IPFS_FN_ANALOG;
      3'b100, 3'b101: pin3_fn = IPFS_FN_INTR;
      3'b110, 3'b111: pin3_fn = IPFS_FN_TIMER;
      default: pin3_fn = IPFS_FN_DIGITAL;
    endcase
  end

  // Pin 3 enables come from the decode, so interrupt and timer can
  // never both receive the pin level
  // Other pins have no such consumers
  always_comb begin
    sel.analog_en = an_en;
    sel.digital_en = dg_en;
    sel.timer_en = (pin3_fn == IPFS_FN_TIMER);
    sel.intr_en = (pin3_fn == IPFS_FN_INTR);
  end

  // Next state; edge flags compare with previous gated level
  always_comb begin
    st_next = st_reg;
    if (MODE_WR) begin
      st_next.int_pin_sel = MODE_WDATA[IPFS_MODE_SEL_BIT];
    end
    st_next.data = PIN_IN & (sel.digital_en | taken);
    st_next.analog = PIN_IN & sel.analog_en;
    st_next.intr_level = PIN_IN[IPFS_SHARED_PIN] & sel.intr_en;
    st_next.timer_level = PIN_IN[IPFS_SHARED_PIN] & sel.timer_en;
    st_next.intr_prev = st_reg.intr_level;
    st_next.timer_prev = st_reg.timer_level;
    // Edge_sel[0] picks interrupt edge, edge_sel[1] timer edge (1 rising)
    st_next.intr_edge = CFG.edge_sel[0] ? (st_reg.intr_level && !st_reg.intr_prev)
                                        : (!st_reg.intr_level && st_reg.intr_prev);
    st_next.timer_edge = CFG.edge_sel[1] ? (st_reg.timer_level && !st_reg.timer_prev)
                                         : (!st_reg.timer_level && st_reg.timer_prev);
    // Leaving a function must not fake an edge
    if (!sel.intr_en) begin
      st_next.intr_edge = 1'b0;
    end
    if (!sel.timer_en) begin
      st_next.timer_edge = 1'b0;
    end
  end

  // Register the whole state
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      st_reg <= '0;
      st_reg.int_pin_sel <= IPFS_MODE_RESET[IPFS_MODE_SEL_BIT];
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign MODE_RDATA = IPFS_MODE_RSVD | ({7'h00, st_reg.int_pin_sel} << IPFS_MODE_SEL_BIT);
  assign DATA_RDATA = st_reg.data;
  assign ANALOG_EN = sel.analog_en;
  assign ANALOG_PIN = st_reg.analog;
  assign INTR_EN = sel.intr_en;
  assign INTR_LEVEL = st_reg.intr_level;
  assign INTR_EDGE = st_reg.intr_edge; // intr_edge clears a cycle after the timer takes the pin; INTR_EDGE can still be high in that first cycle
  assign TIMER_EN = sel.timer_en;
  assign TIMER_LEVEL = st_reg.timer_level;
  assign TIMER_EDGE = st_reg.timer_edge;
endmodule

// ==== hdl/ipfs_pkg.sv ====
// Package for the input port pin function select block
package ipfs_pkg;
  localparam int IPFS_PINS = 8;
  localparam logic [7:0] IPFS_MODE_RESET = 8'hf7;
  localparam logic [7:0] IPFS_MODE_RSVD = 8'hf7;
  localparam int IPFS_MODE_SEL_BIT = 3;
  localparam int IPFS_SHARED_PIN = 3;
  localparam logic [3:0] IPFS_CH0 = 4'h4;
  localparam logic [3:0] IPFS_CH1 = 4'h5;
  localparam logic [3:0] IPFS_CH2 = 4'h6;
  localparam logic [3:0] IPFS_CH3 = 4'h7;
  localparam logic [3:0] IPFS_CH4 = 4'h8;
  localparam logic [3:0] IPFS_CH5 = 4'h9;
  localparam logic [3:0] IPFS_CH6 = 4'ha;
  localparam logic [3:0] IPFS_CH7 = 4'hb;
  localparam logic [2:0] IPFS_TMR_EXT = 3'h7;

  // Per-pin function for the shared pin
  typedef enum logic [1:0] {
    IPFS_FN_DIGITAL = 2'b00,
    IPFS_FN_ANALOG = 2'b01,
    IPFS_FN_INTR = 2'b10,
    IPFS_FN_TIMER = 2'b11
  } ipfs_fn_e;

  // Configuration fields seen by the selector
  typedef struct packed {
    logic [3:0] channel;
    logic [2:0] timer_clk;
    logic [1:0] edge_sel;
  } ipfs_cfg_s;

  // Per-pin function enables
  typedef struct packed {
    logic [7:0] digital_en;
    logic [7:0] analog_en;
    logic intr_en;
    logic timer_en;
  } ipfs_sel_s;

  // Registered state of the top
  typedef struct packed {
    logic int_pin_sel;
    logic [7:0] data;
    logic [7:0] analog;
    logic intr_level;
    logic timer_level;
    logic intr_prev;
    logic timer_prev;
    logic intr_edge;
    logic timer_edge;
  } ipfs_state_s;
endpackage

// ==== hdl/ipfs_pin_sel.sv ====
// Combinational function selector for one analog-capable pin
`timescale 1ns/1ps
module ipfs_pin_sel #(
  parameter logic [3:0] CODE = 4'h0
) (
  // Current channel field
  input wire logic [3:0] channel,
  // Whether pin is taken by another function
  input wire logic taken,
  // Resulting enables
  output logic analog_en,
  output logic digital_en
);
  import ipfs_pkg::*;
  // One enable per pin; taken pins are neither digital nor analog here
  assign analog_en = !taken && (channel == CODE);
  assign digital_en = !taken && (channel != CODE);
endmodule

// ==== testbench/ipfs_chk.sv ====
// Port checker for the input port pin function select
`timescale 1ns/1ps
module ipfs_chk (
  // Clock, reset and mode access
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic MODE_WR,
  input wire logic [7:0] MODE_WDATA,
  input wire logic [7:0] MODE_RDATA,
  // Configuration, pins and consumers
  input wire ipfs_pkg::ipfs_cfg_s CFG,
  input wire logic [7:0] PIN_IN,
  input wire logic [7:0] DATA_RDATA,
  input wire logic [7:0] ANALOG_EN,
  input wire logic INTR_EN,
  input wire logic INTR_LEVEL,
  input wire logic INTR_EDGE,
  input wire logic TIMER_EN
);
  import ipfs_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  logic s;
  logic [7:0] dec;
  // Expected one-hot decode; pin 3 is judged apart
  assign s = MODE_RDATA[3];
  assign dec = (CFG.channel > 4'h3 && CFG.channel < 4'hc) ? 8'h01 << (CFG.channel - 4'h4) : 8'h00;
  // Data check only with a steady decode, since the read is one cycle late
  a_mode_rsvd: assert property ((MODE_RDATA | 8'h08) == 8'hff) else $error("mode rsvd");
  a_sel_take: assert property (MODE_WR |=> s == $past(MODE_WDATA[3])) else $error("sel");
  a_pin3_an: assert property (ANALOG_EN[3] == (!s && CFG.channel == IPFS_CH3)) else $error("an3");
  a_intr_sel: assert property (INTR_EN == (s && CFG.timer_clk != IPFS_TMR_EXT)) else $error("irq");
  a_timer_sel: assert property (TIMER_EN == (s && CFG.timer_clk == IPFS_TMR_EXT)) else $error("tmr");
  a_an_decode: assert property ((ANALOG_EN & 8'hf7) == (dec & 8'hf7)) else $error("an");
  a_data_mask: assert property (!$past(SRST) && $stable(CFG) && $stable(s) |->
    DATA_RDATA == ($past(PIN_IN) & ~ANALOG_EN)) else $error("data");
  a_edge_once: assert property (INTR_EDGE |-> $past(INTR_LEVEL) != $past(INTR_LEVEL, 2) ##1 !INTR_EDGE)
    else $error("edge");
  // Main scenarios seen
  cover property (MODE_WR && MODE_WDATA[3]);
  cover property (INTR_EDGE);
  cover property (TIMER_EN);
endmodule
bind ipfs_top ipfs_chk ipfs_chk_i (.*);

// ==== testbench/ipfs_pins.sv ====
// Model of the external pins of the input port
`timescale 1ns/1ps
module ipfs_pins (
  // Clock and requested levels
  input wire logic CLOCK,
  input wire logic [7:0] LEVEL,
  // Pins toward the block
  output logic [7:0] PIN_IN
);
  // Pins follow one rising edge late, like a slow source
  initial PIN_IN = 8'h00;
  always @(posedge CLOCK) begin
    PIN_IN <= LEVEL;
  end
endmodule

// ==== testbench/tb_ipfs_top.sv ====
// Self-checking bench for the input port pin function select
`timescale 1ns/1ps
module tb_ipfs_top;
  import ipfs_pkg::*;
  logic CLOCK = 1'b0;
  logic SRST = 1'b1;
  logic MODE_WR = 1'b0;
  logic [7:0] MODE_WDATA = 8'h00;
  logic [7:0] LEVEL = 8'h00;
  ipfs_cfg_s CFG = '0;
  logic [7:0] PIN_IN, MODE_RDATA, DATA_RDATA, ANALOG_EN, ANALOG_PIN;
  logic INTR_EN, INTR_LEVEL, INTR_EDGE, TIMER_EN, TIMER_LEVEL, TIMER_EDGE;
  int err_total = 0;
  int n_compared = 0;
  // 100 ns clock
  initial forever #50 CLOCK = ~CLOCK;
  ipfs_pins ipfs_pins_i (.*);
  ipfs_top ipfs_top_i (.*);
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_mode(input logic [7:0] d);
    MODE_WR = 1'b1;
    MODE_WDATA = d;
    tick(1);
    MODE_WR = 1'b0;
    tick(1);
  endtask
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Reset value, select write, reserved ones
  task automatic t_mode;
    chk(MODE_RDATA, 8'hf7);
    wr_mode(8'h08);
    chk(MODE_RDATA, 8'hff);
    wr_mode(8'hf7);
    chk(MODE_RDATA, 8'hf7);
  endtask
  // Every channel code; analog pins read 0
  task automatic t_chan;
    logic [7:0] exp;
    LEVEL = 8'hff;
    for (int c = 0; c < 16; c++) begin
      CFG.channel = c[3:0];
      exp = (c > 3 && c < 12) ? 8'h01 << (c - 4) : 8'h00;
      tick(3);
      chk(ANALOG_EN, exp);
      chk(DATA_RDATA, ~exp);
      chk(ANALOG_PIN, exp);
    end
  endtask
  // Pin 3 with select set, every timer clock code
  task automatic t_pin3;
    wr_mode(8'h08);
    CFG.channel = IPFS_CH3;
    for (int t = 0; t < 8; t++) begin
      CFG.timer_clk = t[2:0];
      tick(1);
      chk({5'h00, ANALOG_EN[3], INTR_EN, TIMER_EN}, {6'h00, t != 7, t == 7});
    end
  endtask
  // Rise then fall on pin 3 for both functions and edges
  task automatic t_edge;
    logic [3:0] cnt [3];
    logic [3:0] oth;
    LEVEL = 8'h00;
    for (int m = 0; m < 4; m++) begin
      // Modes 2 and 3 give the pin to the timer; the unused consumer must see no edge
      CFG.timer_clk = m[1] ? IPFS_TMR_EXT : 3'h0;
      CFG.edge_sel = {m[0], m[0]};
      cnt = '{default: 4'h0};
      oth = 4'h0;
      for (int p = 0; p < 18; p++) begin
        LEVEL = (p / 6 == 1) ? 8'h08 : 8'h00;
        tick(1);
        cnt[p / 6] = cnt[p / 6] + {3'h0, m[1] ? TIMER_EDGE : INTR_EDGE};
        oth = oth + {3'h0, m[1] ? INTR_EDGE : TIMER_EDGE};
        if (p == 10) chk({6'h00, INTR_LEVEL, TIMER_LEVEL}, {6'h00, !m[1], m[1]});
      end
      chk({cnt[1], cnt[2]}, {3'h0, m[0], 3'h0, !m[0]});
      chk({4'h0, oth}, 8'h00);
    end
  endtask
  // Main sequence
  initial begin
    tick(16);
    SRST = 1'b0;
    tick(1);
    t_mode();
    t_chan();
    t_pin3();
    t_edge();
    wrap_up();
  end
  // Watchdog, over six times the expected run
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule
